// ---- rtl/ira_top.sv ----
/*
  Indirect register access block: Avalon-MM register slave with waitrequest,
  reaching analog block registers through an offset/data window and an
  internal read-only APB space through a start-read window.
  Assumes analog blocks and APB targets run on i_sys_clk; the Avalon master
  holds its request until it samples waitrequest low.
*/
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ira_top (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [9:0] i_avs_address,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [2:0] o_ana_sel,
  output logic [7:0] o_ana_addr,
  output logic [7:0] o_ana_wdata,
  output logic o_ana_wr,
  output logic o_ana_rd,
  input wire logic [7:0] i_ana_rdata,
  input wire logic i_ana_ack,
  output logic o_apb_psel,
  output logic o_apb_penable,
  output logic o_apb_pwrite,
  output logic [7:0] o_apb_paddr,
  output logic [1:0] o_apb_target,
  input wire logic [7:0] i_apb_prdata,
  input wire logic i_apb_pready
);
  import ira_pkg::*;

  ira_avs_state_t avs_state_ff, nxt_avs_state;
  logic [31:0] readdata_ff;
  logic [7:0] rd_byte;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic avs_req;
  logic data_trig;
  logic commit_wr;

  logic [2:0] ana_sel_ff;
  logic ana_inc_ff;
  logic ana_dir_ff;
  logic [7:0] ana_ofs_ff;
  logic [7:0] ana_data_ff;
  logic ana_rsvd_ff;

  logic [1:0] bus_sel_ff;
  logic bus_inc_ff;
  logic bus_read_ff;
  logic bus_en_ff;
  logic [7:0] bus_adr_ff;
  logic [7:0] bus_data_ff;
  logic bus_refused_ff;

  ira_ana_req_t ana_req;
  logic ana_go;
  logic ana_done;
  logic ana_real;
  logic [7:0] ana_rdata;

  ira_bus_req_t bus_req;
  logic bus_start;
  logic bus_busy;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic bus_start_ok;
  logic bus_start_wr;

  // registers sit one per word; the low two address bits are ignored
  assign idx = i_avs_address[9:2];
  assign wbyte = i_avs_writedata[7:0];
  assign avs_req = i_avs_read | i_avs_write;

  // only a data-port access in the active direction goes out to a block
  assign data_trig = (idx == IRA_IDX_ANA_DATA) &&
                     ((i_avs_write && i_avs_byteenable[0] && !ana_dir_ff) ||
                      (i_avs_read && ana_dir_ff));

  // a write lands at the edge where the master sees waitrequest low
  assign commit_wr = (avs_state_ff == IRA_AVS_ACK) && i_avs_write && i_avs_byteenable[0];

  assign o_avs_waitrequest = avs_req && (avs_state_ff != IRA_AVS_ACK);
  assign o_avs_readdata = readdata_ff;

  always_comb begin
    nxt_avs_state = avs_state_ff;
    ana_go = 1'b0;
    case (avs_state_ff)
      IRA_AVS_IDLE: begin
        if (avs_req && data_trig) begin
          nxt_avs_state = IRA_AVS_INDIRECT;
          ana_go = 1'b1;
        end else if (avs_req) begin
          nxt_avs_state = IRA_AVS_ACK;
        end
      end
      IRA_AVS_INDIRECT: begin
        if (ana_done) begin
          nxt_avs_state = IRA_AVS_ACK;
        end
      end
      IRA_AVS_ACK: nxt_avs_state = IRA_AVS_IDLE;
      default: nxt_avs_state = IRA_AVS_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      avs_state_ff <= IRA_AVS_IDLE;
    end else begin
      avs_state_ff <= nxt_avs_state;
    end
  end

  always_comb begin
    rd_byte = IRA_RST_BYTE;
    case (idx)
      IRA_IDX_ANA_CTL: begin
        rd_byte[IRA_ANA_SEL_HI:IRA_ANA_SEL_LO] = ana_sel_ff;
        rd_byte[IRA_ANA_INC_BIT] = ana_inc_ff;
        rd_byte[IRA_ANA_DIR_BIT] = ana_dir_ff;
      end
      IRA_IDX_ANA_OFS: rd_byte = ana_ofs_ff;
      IRA_IDX_ANA_DATA: rd_byte = ana_data_ff;
      IRA_IDX_BUS_CTL: begin
        rd_byte[IRA_BUS_SEL_HI:IRA_BUS_SEL_LO] = bus_sel_ff;
        rd_byte[IRA_BUS_INC_BIT] = bus_inc_ff;
        rd_byte[IRA_BUS_READ_BIT] = bus_read_ff;
        rd_byte[IRA_BUS_EN_BIT] = bus_en_ff;
      end
      IRA_IDX_BUS_ADR: rd_byte = bus_adr_ff;
      IRA_IDX_BUS_DATA: rd_byte = bus_data_ff;
      IRA_IDX_STATUS: begin
        rd_byte[IRA_STS_ANA_BUSY_BIT] = avs_state_ff == IRA_AVS_INDIRECT;
        rd_byte[IRA_STS_BUS_BUSY_BIT] = bus_busy;
        rd_byte[IRA_STS_ANA_RSVD_BIT] = ana_rsvd_ff;
        rd_byte[IRA_STS_BUS_REFUSED_BIT] = bus_refused_ff;
      end
      default: rd_byte = IRA_RST_BYTE;
    endcase
  end

  // read data is latched on entry to ACK and stands through that cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      readdata_ff <= IRA_RST_WORD;
    end else if (avs_state_ff == IRA_AVS_INDIRECT && ana_done) begin
      readdata_ff <= {24'h00_0000, ana_rdata};
    end else if (avs_state_ff == IRA_AVS_IDLE && avs_req && !data_trig) begin
      readdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ana_sel_ff <= IRA_ANA_SEL_OFF;
      ana_inc_ff <= 1'b0;
      ana_dir_ff <= 1'b0;
    end else if (commit_wr && idx == IRA_IDX_ANA_CTL) begin
      ana_sel_ff <= wbyte[IRA_ANA_SEL_HI:IRA_ANA_SEL_LO];
      ana_inc_ff <= wbyte[IRA_ANA_INC_BIT];
      ana_dir_ff <= wbyte[IRA_ANA_DIR_BIT];
    end
  end

  // host write and increment never meet: the increment ends before ACK
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ana_ofs_ff <= IRA_RST_BYTE;
    end else if (commit_wr && idx == IRA_IDX_ANA_OFS) begin
      ana_ofs_ff <= wbyte;
    end else if (ana_real && ana_inc_ff) begin
      ana_ofs_ff <= ana_ofs_ff + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ana_data_ff <= IRA_RST_BYTE;
    end else if (commit_wr && idx == IRA_IDX_ANA_DATA) begin
      ana_data_ff <= wbyte;
    end else if (ana_done && ana_dir_ff) begin
      ana_data_ff <= ana_rdata;
    end
  end

  // sticky: an access with a disabled or reserved selector; set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ana_rsvd_ff <= 1'b0;
    end else if (ana_done && !ana_real) begin
      ana_rsvd_ff <= 1'b1;
    end else if (commit_wr && idx == IRA_IDX_STATUS && wbyte[IRA_STS_ANA_RSVD_BIT]) begin
      ana_rsvd_ff <= 1'b0;
    end
  end

  assign ana_req.rd = ana_dir_ff;
  assign ana_req.sel = ana_sel_ff;
  assign ana_req.offset = ana_ofs_ff;
  assign ana_req.wdata = i_avs_write ? wbyte : ana_data_ff;

  ira_ana_port u_ana_port (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_go(ana_go),
    .i_req(ana_req),
    .o_done(ana_done),
    .o_real(ana_real),
    .o_rdata(ana_rdata),
    .o_port_sel(o_ana_sel),
    .o_port_addr(o_ana_addr),
    .o_port_wdata(o_ana_wdata),
    .o_port_wr(o_ana_wr),
    .o_port_rd(o_ana_rd),
    .i_port_rdata(i_ana_rdata),
    .i_port_ack(i_ana_ack)
  );

  // a start is taken only when enabled towards a defined target
  assign bus_start_ok = wbyte[IRA_BUS_EN_BIT] &&
                        (wbyte[IRA_BUS_SEL_HI:IRA_BUS_SEL_LO] == IRA_BUS_SEL_CFG ||
                         wbyte[IRA_BUS_SEL_HI:IRA_BUS_SEL_LO] == IRA_BUS_SEL_DIEID);
  assign bus_start_wr = commit_wr && idx == IRA_IDX_BUS_CTL && wbyte[IRA_BUS_READ_BIT];

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_sel_ff <= 2'h0;
      bus_inc_ff <= 1'b0;
      bus_en_ff <= 1'b0;
    end else if (commit_wr && idx == IRA_IDX_BUS_CTL) begin
      bus_sel_ff <= wbyte[IRA_BUS_SEL_HI:IRA_BUS_SEL_LO];
      bus_inc_ff <= wbyte[IRA_BUS_INC_BIT];
      bus_en_ff <= wbyte[IRA_BUS_EN_BIT];
    end
  end

  // a new start in the completion cycle wins over the self-clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_read_ff <= 1'b0;
    end else if (bus_start_wr && bus_start_ok) begin
      bus_read_ff <= 1'b1;
    end else if (bus_done) begin
      bus_read_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_refused_ff <= 1'b0;
    end else if (bus_start_wr && !bus_start_ok) begin
      bus_refused_ff <= 1'b1;
    end else if (commit_wr && idx == IRA_IDX_STATUS && wbyte[IRA_STS_BUS_REFUSED_BIT]) begin
      bus_refused_ff <= 1'b0;
    end
  end

  // host write wins over the increment so software can always re-aim
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_adr_ff <= IRA_RST_BYTE;
    end else if (commit_wr && idx == IRA_IDX_BUS_ADR) begin
      bus_adr_ff <= wbyte;
    end else if (bus_done && bus_inc_ff) begin
      bus_adr_ff <= bus_adr_ff + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_data_ff <= IRA_RST_BYTE;
    end else if (bus_done) begin
      bus_data_ff <= bus_rdata;
    end else if (commit_wr && idx == IRA_IDX_BUS_DATA) begin
      bus_data_ff <= wbyte;
    end
  end

  // done blocks a relaunch in the cycle before the start bit drops
  assign bus_start = bus_read_ff && !bus_busy && !bus_done;
  assign bus_req.target = bus_sel_ff;
  assign bus_req.addr = bus_adr_ff;

  ira_bus_master u_bus_master (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_start(bus_start),
    .i_req(bus_req),
    .o_busy(bus_busy),
    .o_done(bus_done),
    .o_rdata(bus_rdata),
    .o_psel(o_apb_psel),
    .o_penable(o_apb_penable),
    .o_pwrite(o_apb_pwrite),
    .o_paddr(o_apb_paddr),
    .o_ptarget(o_apb_target),
    .i_prdata(i_apb_prdata),
    .i_pready(i_apb_pready)
  );

endmodule

// ---- rtl/ira_pkg.sv ----
/*
  Shared constants and types for the indirect register access block:
  register indices, field positions, reset values, target codes, FSM states.
  Assumes a byte-wide register view with one register per 32-bit bus word.
*/
// What this block does
// - analog selector 000 off, 100 video receiver, 101 serial transmitter, else reserved
// - analog auto-increment adds one to offset after each completed access to a valid selector
// - analog direction bit: 0 data port writes, 1 data port reads
// - analog offset register holds the 8-bit offset of every indirect access
// - host write to analog data port triggers indirect write at current offset
// - host read of analog data port returns selected analog register contents
// - internal bus selector: 10 configuration data, 11 die identifier, else reserved
// - internal bus auto-increment advances address by one after each completed access
// - writing start-read issues internal bus read, result lands in data low register
// - start-read bit clears itself when the internal bus read finishes
// - internal bus works only while enabled, towards the selected target
// - address low register supplies address byte, resets to 0x00
// - data low register holds the byte moved over the internal bus
package ira_pkg;

  localparam logic [7:0] IRA_IDX_ANA_CTL = 8'h40;
  localparam logic [7:0] IRA_IDX_ANA_OFS = 8'h41;
  localparam logic [7:0] IRA_IDX_ANA_DATA = 8'h42;
  localparam logic [7:0] IRA_IDX_BUS_CTL = 8'h48;
  localparam logic [7:0] IRA_IDX_BUS_ADR = 8'h49;
  localparam logic [7:0] IRA_IDX_BUS_DATA = 8'h4b;
  localparam logic [7:0] IRA_IDX_STATUS = 8'h4e;

  localparam int IRA_ANA_SEL_HI = 4;
  localparam int IRA_ANA_SEL_LO = 2;
  localparam int IRA_ANA_INC_BIT = 1;
  localparam int IRA_ANA_DIR_BIT = 0;
  localparam int IRA_BUS_SEL_HI = 4;
  localparam int IRA_BUS_SEL_LO = 3;
  localparam int IRA_BUS_INC_BIT = 2;
  localparam int IRA_BUS_READ_BIT = 1;
  localparam int IRA_BUS_EN_BIT = 0;
  localparam int IRA_STS_ANA_BUSY_BIT = 0;
  localparam int IRA_STS_BUS_BUSY_BIT = 1;
  localparam int IRA_STS_ANA_RSVD_BIT = 2;
  localparam int IRA_STS_BUS_REFUSED_BIT = 3;

  localparam logic [7:0] IRA_RST_BYTE = 8'h00;
  localparam logic [31:0] IRA_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] IRA_ANA_IDLE_DATA = 8'h00;

  localparam logic [2:0] IRA_ANA_SEL_OFF = 3'h0;
  localparam logic [2:0] IRA_ANA_SEL_VIDRX = 3'h4;
  localparam logic [2:0] IRA_ANA_SEL_SERTX = 3'h5;
  localparam logic [1:0] IRA_BUS_SEL_CFG = 2'h2;
  localparam logic [1:0] IRA_BUS_SEL_DIEID = 2'h3;

  typedef struct packed {
    logic rd;
    logic [2:0] sel;
    logic [7:0] offset;
    logic [7:0] wdata;
  } ira_ana_req_t;

  typedef struct packed {
    logic [1:0] target;
    logic [7:0] addr;
  } ira_bus_req_t;

  typedef enum logic [1:0] {
    IRA_ANA_IDLE = 2'b00,
    IRA_ANA_WAIT = 2'b01,
    IRA_ANA_SKIP = 2'b10
  } ira_ana_state_t;

  typedef enum logic [1:0] {
    IRA_BUS_IDLE = 2'b00,
    IRA_BUS_SETUP = 2'b01,
    IRA_BUS_ACCESS = 2'b10
  } ira_bus_state_t;

  typedef enum logic [1:0] {
    IRA_AVS_IDLE = 2'b00,
    IRA_AVS_INDIRECT = 2'b01,
    IRA_AVS_ACK = 2'b10
  } ira_avs_state_t;

endpackage

// ---- rtl/ira_ana_port.sv ----
/*
  Analog register port engine: runs one indirect read or write towards the
  selected analog block. Assumes the analog blocks share i_sys_clk and answer
  a held strobe with a one-cycle i_port_ack carrying read data.
*/
`timescale 1ns/1ps
module ira_ana_port (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_go,
  input wire ira_pkg::ira_ana_req_t i_req,
  output logic o_done,
  output logic o_real,
  output logic [7:0] o_rdata,
  output logic [2:0] o_port_sel,
  output logic [7:0] o_port_addr,
  output logic [7:0] o_port_wdata,
  output logic o_port_wr,
  output logic o_port_rd,
  input wire logic [7:0] i_port_rdata,
  input wire logic i_port_ack
);
  import ira_pkg::*;

  ira_ana_state_t state_ff, nxt_state;
  ira_ana_req_t req_ff;
  logic sel_valid;

  assign sel_valid = (i_req.sel == IRA_ANA_SEL_VIDRX) || (i_req.sel == IRA_ANA_SEL_SERTX);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IRA_ANA_IDLE: begin
        if (i_go) begin
          nxt_state = sel_valid ? IRA_ANA_WAIT : IRA_ANA_SKIP;
        end
      end
      IRA_ANA_WAIT: begin
        if (i_port_ack) begin
          nxt_state = IRA_ANA_IDLE;
        end
      end
      IRA_ANA_SKIP: nxt_state = IRA_ANA_IDLE;
      default: nxt_state = IRA_ANA_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff <= IRA_ANA_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      req_ff <= '0;
    end else if (state_ff == IRA_ANA_IDLE && i_go) begin
      req_ff <= i_req;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_done <= 1'b0;
      o_real <= 1'b0;
      o_rdata <= IRA_RST_BYTE;
    end else begin
      o_done <= (state_ff == IRA_ANA_WAIT && i_port_ack) || state_ff == IRA_ANA_SKIP;
      o_real <= state_ff == IRA_ANA_WAIT && i_port_ack;
      if (state_ff == IRA_ANA_WAIT && i_port_ack) begin
        o_rdata <= req_ff.rd ? i_port_rdata : req_ff.wdata;
      end else if (state_ff == IRA_ANA_SKIP) begin
        o_rdata <= IRA_ANA_IDLE_DATA;
      end
    end
  end

  // strobes only exist in WAIT, so a disabled selector never reaches a block
  assign o_port_sel = req_ff.sel;
  assign o_port_addr = req_ff.offset;
  assign o_port_wdata = req_ff.wdata;
  assign o_port_wr = state_ff == IRA_ANA_WAIT && !req_ff.rd;
  assign o_port_rd = state_ff == IRA_ANA_WAIT && req_ff.rd;

endmodule

// ---- rtl/ira_bus_master.sv ----
/*
  Internal APB read master: one read per start towards the selected target.
  Assumes the targets are read-only, share i_sys_clk and use pready.
*/
`timescale 1ns/1ps
module ira_bus_master (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire ira_pkg::ira_bus_req_t i_req,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [1:0] o_ptarget,
  input wire logic [7:0] i_prdata,
  input wire logic i_pready
);
  import ira_pkg::*;

  ira_bus_state_t state_ff, nxt_state;
  ira_bus_req_t req_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IRA_BUS_IDLE: begin
        if (i_start) begin
          nxt_state = IRA_BUS_SETUP;
        end
      end
      IRA_BUS_SETUP: nxt_state = IRA_BUS_ACCESS;
      IRA_BUS_ACCESS: begin
        if (i_pready) begin
          nxt_state = IRA_BUS_IDLE;
        end
      end
      default: nxt_state = IRA_BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff <= IRA_BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // start is only sampled in IDLE, so a pending read is never overlapped
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      req_ff <= '0;
    end else if (state_ff == IRA_BUS_IDLE && i_start) begin
      req_ff <= i_req;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_done <= 1'b0;
      o_rdata <= IRA_RST_BYTE;
    end else begin
      o_done <= state_ff == IRA_BUS_ACCESS && i_pready;
      if (state_ff == IRA_BUS_ACCESS && i_pready) begin
        o_rdata <= i_prdata;
      end
    end
  end

  assign o_busy = state_ff != IRA_BUS_IDLE;
  assign o_psel = state_ff != IRA_BUS_IDLE;
  assign o_penable = state_ff == IRA_BUS_ACCESS;
  assign o_pwrite = 1'b0;
  assign o_paddr = req_ff.addr;
  assign o_ptarget = req_ff.target;

endmodule

// ---- sim/ira_top_properties.sv ----
/*
  Checker for ira_top: analog port strobes and internal bus phases.
  Assumes it is bound to ira_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module ira_top_properties (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [2:0] o_ana_sel,
  input wire logic [7:0] o_ana_addr,
  input wire logic [7:0] o_ana_wdata,
  input wire logic o_ana_wr,
  input wire logic o_ana_rd,
  input wire logic i_ana_ack,
  input wire logic o_apb_psel,
  input wire logic o_apb_penable,
  input wire logic o_apb_pwrite,
  input wire logic [7:0] o_apb_paddr,
  input wire logic [1:0] o_apb_target,
  input wire logic i_apb_pready
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  property p_ana_target;
    (o_ana_wr || o_ana_rd) |-> (o_ana_sel == 3'h4 || o_ana_sel == 3'h5);
  endproperty
  a_ana_target: assert property (p_ana_target) else $error("analog strobe, bad selector");
  property p_ana_dir;
    !(o_ana_wr && o_ana_rd);
  endproperty
  a_ana_dir: assert property (p_ana_dir) else $error("analog read and write together");
  property p_ana_hold;
    (o_ana_wr && !i_ana_ack) |=> o_ana_wr && $stable(o_ana_addr) && $stable(o_ana_wdata);
  endproperty
  a_ana_hold: assert property (p_ana_hold) else $error("analog write dropped or changed");
  property p_ana_release;
    ((o_ana_wr || o_ana_rd) && i_ana_ack) |=> !o_ana_wr && !o_ana_rd;
  endproperty
  a_ana_release: assert property (p_ana_release) else $error("analog strobe after ack");
  property p_apb_rdonly;
    !o_apb_pwrite;
  endproperty
  a_apb_rdonly: assert property (p_apb_rdonly) else $error("internal bus write seen");
  property p_apb_target;
    o_apb_psel |-> o_apb_target[1];
  endproperty
  a_apb_target: assert property (p_apb_target) else $error("reserved bus target");
  property p_apb_setup;
    $rose(o_apb_psel) |-> !o_apb_penable ##1 (o_apb_psel && o_apb_penable);
  endproperty
  a_apb_setup: assert property (p_apb_setup) else $error("bus setup phase wrong");
  property p_apb_hold;
    (o_apb_penable && !i_apb_pready) |=> o_apb_psel && o_apb_penable && $stable(o_apb_paddr);
  endproperty
  a_apb_hold: assert property (p_apb_hold) else $error("bus access not held");
  property p_apb_end;
    (o_apb_penable && i_apb_pready) |=> !o_apb_psel [*2];
  endproperty
  a_apb_end: assert property (p_apb_end) else $error("bus transfer overlaps");
  c_ana_wr: cover property (o_ana_wr && i_ana_ack);
  c_ana_rd: cover property (o_ana_rd && i_ana_ack);
  c_apb_rd: cover property (o_apb_penable && i_apb_pready);
endmodule
bind ira_top ira_top_properties i_props (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .o_ana_sel(o_ana_sel),
  .o_ana_addr(o_ana_addr), .o_ana_wdata(o_ana_wdata), .o_ana_wr(o_ana_wr),
  .o_ana_rd(o_ana_rd), .i_ana_ack(i_ana_ack), .o_apb_psel(o_apb_psel),
  .o_apb_penable(o_apb_penable), .o_apb_pwrite(o_apb_pwrite), .o_apb_paddr(o_apb_paddr),
  .o_apb_target(o_apb_target), .i_apb_pready(i_apb_pready)
);

// ---- sim/ira_top_test.sv ----
/*
  Self-checking bench for ira_top: Avalon register tasks, replies for the
  analog port and the internal bus, scenario sequence and verdict.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
module ira_top_test;
  import ira_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [9:0] i_avs_address = 10'h000;
  logic [3:0] i_avs_byteenable = 4'h1;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_ana_wr, o_ana_rd, o_apb_psel, o_apb_penable, o_apb_pwrite;
  logic [2:0] o_ana_sel;
  logic [7:0] o_ana_addr, o_ana_wdata, o_apb_paddr, q;
  logic [1:0] o_apb_target;
  logic [7:0] i_ana_rdata = 8'h00;
  logic [7:0] i_apb_prdata = 8'h00;
  logic i_ana_ack = 1'b0;
  logic i_apb_pready = 1'b0;
  logic [7:0] ana_mem [2][256];
  logic [2:0] bad [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [7:0] bus_bad [3] = '{8'h12, 8'h03, 8'h0b};
  logic [2:0] sel;
  int errors = 0;
  int checks_done = 0;
  int ana_dly = 0, apb_dly = 0, ana_cnt = 0, apb_cnt = 0, ana_hits = 0, apb_hits = 0, hits;
  ira_top i_dut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_byteenable(i_avs_byteenable), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_ana_sel(o_ana_sel), .o_ana_addr(o_ana_addr),
    .o_ana_wdata(o_ana_wdata), .o_ana_wr(o_ana_wr), .o_ana_rd(o_ana_rd),
    .i_ana_rdata(i_ana_rdata), .i_ana_ack(i_ana_ack), .o_apb_psel(o_apb_psel),
    .o_apb_penable(o_apb_penable), .o_apb_pwrite(o_apb_pwrite), .o_apb_paddr(o_apb_paddr),
    .o_apb_target(o_apb_target), .i_apb_prdata(i_apb_prdata), .i_apb_pready(i_apb_pready)
  );
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [7:0] apb_val(input logic [1:0] t, input logic [7:0] a);
    return a ^ (t[0] ? 8'ha5 : 8'h5a);
  endfunction
  // data lines toggle between answers so a stale sample never matches
  always @(posedge i_sys_clk) begin
    if ((o_ana_wr || o_ana_rd) && !i_ana_ack && ana_cnt >= ana_dly) begin
      i_ana_ack <= 1'b1;
      i_ana_rdata <= ana_mem[o_ana_sel[0]][o_ana_addr];
      if (o_ana_wr) ana_mem[o_ana_sel[0]][o_ana_addr] <= o_ana_wdata;
      ana_cnt <= 0;
      ana_hits <= ana_hits + 1;
    end else begin
      i_ana_ack <= 1'b0;
      i_ana_rdata <= ~i_ana_rdata;
      ana_cnt <= (o_ana_wr || o_ana_rd) ? ana_cnt + 1 : 0;
    end
    if (o_apb_psel && o_apb_penable && !i_apb_pready && apb_cnt >= apb_dly) begin
      i_apb_pready <= 1'b1;
      i_apb_prdata <= apb_val(o_apb_target, o_apb_paddr);
      apb_cnt <= 0;
      apb_hits <= apb_hits + 1;
    end else begin
      i_apb_pready <= 1'b0;
      i_apb_prdata <= ~i_apb_prdata;
      apb_cnt <= (o_apb_psel && o_apb_penable) ? apb_cnt + 1 : 0;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request stands until the rising edge that sees waitrequest low
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    logic wt;
    n = 0;
    wt = 1'b1;
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h000000, d};
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    while (wt !== 1'b0 && n < 100) begin
      @(posedge i_sys_clk);
      wt = o_avs_waitrequest;
      n++;
    end
    q = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    chk("waitrequest", 8'h00, {7'h00, wt});
    chk("readdata upper", 8'h00, {7'h00, |o_avs_readdata[31:8]});
    @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(what, exp, q);
  endtask
  task automatic wait_bus();
    int n;
    n = 0;
    q = 8'h02;
    while (q[1] !== 1'b0 && n < 50) begin
      xfer(1'b0, IRA_IDX_BUS_CTL, 8'h00);
      n++;
    end
    chk("start bit", 8'h00, {6'h00, q[1], 1'b0});
  endtask
  task automatic reset_vals();
    logic [7:0] idx [7] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h49, 8'h4b, 8'h7f};
    foreach (idx[i]) rd_chk("reset value", idx[i], 8'h00);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    final_report();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      ana_mem[0][i] = 8'h3c ^ 8'(i);
      ana_mem[1][i] = 8'hc3 ^ 8'(i);
    end
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    reset_vals();
    wr(8'h7f, 8'hff);
    rd_chk("unmapped", 8'h7f, 8'h00);
    for (int s = 0; s < 2; s++) begin
      sel = s ? IRA_ANA_SEL_SERTX : IRA_ANA_SEL_VIDRX;
      ana_dly = 3 * s;
      wr(IRA_IDX_ANA_CTL, {3'h0, sel, 2'b10});
      wr(IRA_IDX_ANA_OFS, 8'hfe);
      wr(IRA_IDX_ANA_DATA, 8'h11);
      wr(IRA_IDX_ANA_DATA, 8'h22);
      chk("analog byte fe", 8'h11, ana_mem[s][8'hfe]);
      chk("analog byte ff", 8'h22, ana_mem[s][8'hff]);
      rd_chk("offset wrap", IRA_IDX_ANA_OFS, 8'h00);
      wr(IRA_IDX_ANA_CTL, {3'h0, sel, 2'b11});
      wr(IRA_IDX_ANA_OFS, 8'h10);
      rd_chk("analog read", IRA_IDX_ANA_DATA, ana_mem[s][8'h10]);
      rd_chk("analog read next", IRA_IDX_ANA_DATA, ana_mem[s][8'h11]);
      wr(IRA_IDX_ANA_CTL, {3'h0, sel, 2'b00});
      wr(IRA_IDX_ANA_DATA, 8'h5e);
      rd_chk("offset held", IRA_IDX_ANA_OFS, 8'h12);
      chk("analog byte 12", 8'h5e, ana_mem[s][8'h12]);
    end
    // low lane disabled: write acknowledged but stores and triggers nothing
    i_avs_byteenable <= 4'he;
    wr(IRA_IDX_ANA_OFS, 8'h55);
    wr(IRA_IDX_ANA_DATA, 8'h66);
    i_avs_byteenable <= 4'h1;
    rd_chk("lane off offset", IRA_IDX_ANA_OFS, 8'h12);
    chk("lane off data", 8'h5e, ana_mem[1][8'h12]);
    foreach (bad[i]) begin
      hits = ana_hits;
      wr(IRA_IDX_ANA_CTL, {3'h0, bad[i], 2'b00});
      wr(IRA_IDX_ANA_DATA, 8'h77);
      wr(IRA_IDX_ANA_CTL, {3'h0, bad[i], 2'b01});
      rd_chk("idle selector read", IRA_IDX_ANA_DATA, IRA_ANA_IDLE_DATA);
      chk("idle selector strobes", 8'h00, 8'(ana_hits - hits));
    end
    rd_chk("idle selector flag", IRA_IDX_STATUS, 8'h04);
    wr(IRA_IDX_STATUS, 8'h04);
    for (int t = 2; t < 4; t++) begin
      apb_dly = 2 * t - 4;
      wr(IRA_IDX_BUS_ADR, 8'(8'hfc + t));
      wr(IRA_IDX_BUS_CTL, {3'h0, 2'(t), 3'b111});
      wait_bus();
      rd_chk("bus data", IRA_IDX_BUS_DATA, apb_val(2'(t), 8'(8'hfc + t)));
      rd_chk("bus address inc", IRA_IDX_BUS_ADR, 8'(8'hfd + t));
    end
    apb_dly = 6;
    hits = apb_hits;
    wr(IRA_IDX_BUS_ADR, 8'h40);
    wr(IRA_IDX_BUS_CTL, 8'h13);
    wr(IRA_IDX_BUS_CTL, 8'h13);
    wait_bus();
    chk("bus reads issued", 8'h01, 8'(apb_hits - hits));
    rd_chk("bus address held", IRA_IDX_BUS_ADR, 8'h40);
    rd_chk("bus data cfg", IRA_IDX_BUS_DATA, apb_val(2'h2, 8'h40));
    apb_dly = 0;
    foreach (bus_bad[c]) begin
      hits = apb_hits;
      wr(IRA_IDX_BUS_CTL, bus_bad[c]);
      rd_chk("refused data", IRA_IDX_BUS_DATA, apb_val(2'h2, 8'h40));
      rd_chk("refused data again", IRA_IDX_BUS_DATA, apb_val(2'h2, 8'h40));
      chk("refused reads", 8'h00, 8'(apb_hits - hits));
    end
    rd_chk("refused flag", IRA_IDX_STATUS, 8'h08);
    apb_dly = 6;
    wr(IRA_IDX_BUS_CTL, 8'h13);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    chk("bus idle after reset", 8'h00, {7'h00, o_apb_psel});
    reset_vals();
    final_report();
  end
endmodule
